// >>> rtl/psc_engine.sv
// Post-search confirmation engine: tree descent, confirmation chain,
// flow table check and fallback to the per-profile default structure.
// Assumes a same-clock memory read port answering one read at a time.
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.svh"

module psc_engine (
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                arst_n,
	input  wire logic                clk_en,
	// Search request
	input  wire logic                req_valid,
	input  wire psc_pkg::psc_req_t   req,
	output var  logic                req_ready,
	// Memory read port
	output var  logic                mem_rd,
	output var  logic [23:0]         mem_addr,
	input  wire logic                mem_rvalid,
	input  wire logic [31:0]         mem_rdata,
	// Result
	output var  logic                res_valid,
	output var  psc_pkg::psc_res_t   res,
	// Status
	output var  logic                fatal_err,
	input  wire logic                fatal_clr
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	psc_pkg::psc_state_t state;
	psc_pkg::psc_req_t   cur;
	logic                pend;
	logic [3:0]          wcnt;
	logic [23:0]         base;
	logic [27:0]         nkey_hi;
	logic [31:0]         cs_ctrl;
	logic [23:0]         cs_next;
	logic                hdr_ok;
	logic                found;
	logic                dup;
	psc_pkg::psc_res_t   hit;

	logic [59:0] skey;
	logic [59:0] nkey;
	logic [3:0]  hidx;
	logic [7:0]  ft_idx;
	logic        hdr_eq;
	logic        ft_bit;

	assign skey   = {cur.key.crc, cur.key.profile};
	assign nkey   = {nkey_hi, mem_rdata};
	assign hidx   = wcnt - `PSC_CS_HDR0;
	assign hdr_eq = hdr_ok && (mem_rdata == cur.hdr[hidx]);
	assign ft_idx = cs_ctrl[`PSC_CS_IDX_HI:`PSC_CS_IDX_LO];
	assign ft_bit = mem_rdata[5'd31 - ft_idx[4:0]];

	// ----------------------------------------
	// Search sequencer
	// ----------------------------------------
	// Reads are strictly one at a time; a read answer that lands while
	// clk_en is low is not held here, the memory must hold it.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state     <= psc_pkg::PSC_ST_IDLE;
			cur       <= '0;
			pend      <= 1'b0;
			wcnt      <= 4'h0;
			base      <= 24'h000000;
			nkey_hi   <= 28'h0000000;
			cs_ctrl   <= 32'h00000000;
			cs_next   <= 24'h000000;
			hdr_ok    <= 1'b0;
			found     <= 1'b0;
			dup       <= 1'b0;
			hit       <= '0;
			req_ready <= 1'b0;
			mem_rd    <= 1'b0;
			mem_addr  <= 24'h000000;
			res_valid <= 1'b0;
			res       <= '0;
		end else if (clk_en) begin
			mem_rd    <= 1'b0;
			res_valid <= 1'b0;
			dup       <= 1'b0;
			req_ready <= (state == psc_pkg::PSC_ST_IDLE) && !(req_valid && req_ready);
			if (state != psc_pkg::PSC_ST_IDLE && !pend) begin
				mem_rd   <= 1'b1;
				mem_addr <= base + {18'h00000, wcnt, 2'b00};
				pend     <= 1'b1;
			end
			unique case (state)
				psc_pkg::PSC_ST_IDLE: begin
					if (req_valid && req_ready) begin
						cur   <= req;
						base  <= req.root;
						wcnt  <= `PSC_ND_KEY_HI;
						found <= 1'b0;
						state <= psc_pkg::PSC_ST_NODE;
					end
				end
				psc_pkg::PSC_ST_NODE: begin
					if (pend && mem_rvalid) begin
						pend <= 1'b0;
						unique case (wcnt)
							`PSC_ND_KEY_HI: begin
								nkey_hi <= mem_rdata[27:0];
								wcnt    <= `PSC_ND_KEY_LO;
							end
							`PSC_ND_KEY_LO: begin
								if (nkey == skey)
									wcnt <= `PSC_ND_FIRST_CS;
								else if (skey < nkey)
									wcnt <= `PSC_ND_LEFT;
								else
									wcnt <= `PSC_ND_RIGHT;
							end
							`PSC_ND_FIRST_CS: begin
								base  <= mem_rdata[23:0];
								wcnt  <= `PSC_CS_CTRL;
								state <= psc_pkg::PSC_ST_CS;
							end
							default: begin
								if (mem_rdata[23:0] == 24'h000000) begin
									base  <= `PSC_DEF_BASE +
										{13'h0000, cur.key.profile, 7'h00};
									wcnt  <= 4'h0;
									state <= psc_pkg::PSC_ST_DEF;
								end else begin
									base <= mem_rdata[23:0];
									wcnt <= `PSC_ND_KEY_HI;
								end
							end
						endcase
					end
				end
				psc_pkg::PSC_ST_CS: begin
					if (pend && mem_rvalid) begin
						pend <= 1'b0;
						if (wcnt == `PSC_CS_CTRL) begin
							cs_ctrl <= mem_rdata;
							hdr_ok  <= 1'b1;
							wcnt    <= `PSC_CS_NEXT;
						end else if (wcnt == `PSC_CS_NEXT) begin
							cs_next <= mem_rdata[23:0];
							wcnt    <= `PSC_CS_HDR0;
						end else if (hidx != cur.hdr_len - 4'h1) begin
							hdr_ok <= hdr_eq;
							wcnt   <= wcnt + 4'h1;
						end else if (hdr_eq && cs_ctrl[`PSC_CS_FT_EN]) begin
							base  <= cur.ft_ptr;
							wcnt  <= {1'b0, ft_idx[7:5]};
							state <= psc_pkg::PSC_ST_FT;
						end else if (hdr_eq) begin
							found <= 1'b1;
							dup   <= found;
							hit   <= '{psc_pkg::psc_act_t'(cs_ctrl[`PSC_CS_AGAIN] ?
								psc_pkg::PSC_ACT_RESEARCH : psc_pkg::PSC_ACT_ROUTE),
								psc_pkg::psc_dest_t'(cs_ctrl[`PSC_CS_DEST_HI:`PSC_CS_DEST_LO]),
								cs_ctrl[`PSC_CS_PROF_HI:`PSC_CS_PROF_LO], 1'b0};
							wcnt  <= 4'h0;
							state <= psc_pkg::PSC_ST_FT;
							pend  <= 1'b1;
							// Low hdr_ok tells the chain step no read is due
							hdr_ok <= 1'b0;
						end else begin
							wcnt  <= 4'h0;
							state <= psc_pkg::PSC_ST_FT;
							pend  <= 1'b1;
							hdr_ok <= 1'b0;
						end
					end
				end
				psc_pkg::PSC_ST_FT: begin
					// Also the chain step: entered with pend set and no read
					// issued when the flow check is skipped.
					if (pend && (mem_rvalid || !mem_rd && !hdr_ok || found && !hdr_ok)) begin
						pend <= 1'b0;
					end
					if (pend && (mem_rvalid && hdr_ok || !hdr_ok || wcnt == 4'h0 && !hdr_ok)) begin
						if (hdr_ok && mem_rvalid && ft_bit) begin
							found <= 1'b1;
							dup   <= found;
							hit   <= '{psc_pkg::psc_act_t'(cs_ctrl[`PSC_CS_AGAIN] ?
								psc_pkg::PSC_ACT_RESEARCH : psc_pkg::PSC_ACT_ROUTE),
								psc_pkg::psc_dest_t'(cs_ctrl[`PSC_CS_DEST_HI:`PSC_CS_DEST_LO]),
								cs_ctrl[`PSC_CS_PROF_HI:`PSC_CS_PROF_LO], 1'b0};
						end
						wcnt   <= 4'h0;
						hdr_ok <= 1'b0;
						pend   <= 1'b0;
						if (cs_next != 24'h000000) begin
							base  <= cs_next;
							state <= psc_pkg::PSC_ST_CS;
						end else if (found || (hdr_ok && mem_rvalid && ft_bit)) begin
							res_valid <= 1'b1;
							res       <= (hdr_ok && mem_rvalid && ft_bit && !found) ?
								psc_pkg::psc_res_t'{psc_pkg::psc_act_t'(cs_ctrl[`PSC_CS_AGAIN] ?
								psc_pkg::PSC_ACT_RESEARCH : psc_pkg::PSC_ACT_ROUTE),
								psc_pkg::psc_dest_t'(cs_ctrl[`PSC_CS_DEST_HI:`PSC_CS_DEST_LO]),
								cs_ctrl[`PSC_CS_PROF_HI:`PSC_CS_PROF_LO], 1'b0} : hit;
							state     <= psc_pkg::PSC_ST_IDLE;
						end else begin
							base  <= `PSC_DEF_BASE + {13'h0000, cur.key.profile, 7'h00};
							state <= psc_pkg::PSC_ST_DEF;
						end
					end
				end
				psc_pkg::PSC_ST_DEF: begin
					if (pend && mem_rvalid) begin
						pend      <= 1'b0;
						res_valid <= 1'b1;
						res       <= '{psc_pkg::psc_act_t'(mem_rdata[`PSC_DS_ACT_HI:`PSC_DS_ACT_LO]),
							psc_pkg::PSC_DEST_CPU,
							mem_rdata[`PSC_DS_PROF_HI:`PSC_DS_PROF_LO], 1'b1};
						state     <= psc_pkg::PSC_ST_IDLE;
					end
				end
				default: state <= psc_pkg::PSC_ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Fatal duplicate-match flag
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			fatal_err <= 1'b0;
		else if (clk_en) begin
			if (dup)
				fatal_err <= 1'b1;
			else if (fatal_clr)
				fatal_err <= 1'b0;
		end
	end

endmodule : psc_engine

`default_nettype wire

// >>> pkg/psc_regs.svh
// Constants of the post-search confirmation engine: structure offsets,
// field positions, fixed addresses.
// Assumes byte addresses on a 24-bit external memory read port.
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

// ----------------------------------------
// Fixed default structure addresses
// ----------------------------------------
`define PSC_DEF_BASE      24'h001800
`define PSC_DEF_STRIDE_SH 7
`define PSC_ADDR_W        24

// ----------------------------------------
// Tree node dword indices
// ----------------------------------------
`define PSC_ND_KEY_HI     4'h0
`define PSC_ND_KEY_LO     4'h1
`define PSC_ND_LEFT       4'h2
`define PSC_ND_RIGHT      4'h3
`define PSC_ND_FIRST_CS   4'h4

// ----------------------------------------
// Confirmation structure layout
// ----------------------------------------
`define PSC_CS_CTRL       4'h0
`define PSC_CS_NEXT       4'h1
`define PSC_CS_HDR0       4'h2
`define PSC_CS_FT_EN      31
`define PSC_CS_AGAIN      30
`define PSC_CS_DEST_HI    29
`define PSC_CS_DEST_LO    28
`define PSC_CS_PROF_HI    27
`define PSC_CS_PROF_LO    24
`define PSC_CS_IDX_HI     7
`define PSC_CS_IDX_LO     0

// ----------------------------------------
// Default structure layout
// ----------------------------------------
`define PSC_DS_ACT_HI     31
`define PSC_DS_ACT_LO     30
`define PSC_DS_PROF_HI    27
`define PSC_DS_PROF_LO    24

`endif

// >>> pkg/psc_pkg.sv
// Types of the post-search confirmation engine.
// Assumes psc_regs.svh for the numeric layout.
`default_nettype none
package psc_pkg;

	typedef enum logic [1:0] {
		PSC_DEST_PDU  = 2'b00,
		PSC_DEST_CPU  = 2'b01,
		PSC_DEST_A    = 2'b10,
		PSC_DEST_B    = 2'b11
	} psc_dest_t;

	typedef enum logic [1:0] {
		PSC_ACT_ROUTE    = 2'b00,
		PSC_ACT_DISCARD  = 2'b01,
		PSC_ACT_TO_CPU   = 2'b10,
		PSC_ACT_RESEARCH = 2'b11
	} psc_act_t;

	typedef enum logic [2:0] {
		PSC_ST_IDLE = 3'b000,
		PSC_ST_NODE = 3'b001,
		PSC_ST_CS   = 3'b010,
		PSC_ST_FT   = 3'b011,
		PSC_ST_DEF  = 3'b100
	} psc_state_t;

	typedef struct packed {
		logic [55:0] crc;
		logic [3:0]  profile;
	} psc_key_t;

	typedef struct packed {
		psc_key_t         key;
		logic [23:0]      ft_ptr;
		logic [23:0]      root;
		logic [3:0]       hdr_len;
		logic [9:0][31:0] hdr;
	} psc_req_t;

	typedef struct packed {
		psc_act_t   act;
		psc_dest_t  dest;
		logic [3:0] profile;
		logic       dflt;
	} psc_res_t;

endpackage : psc_pkg
`default_nettype wire

// >>> verification/psc_mem_model.sv
// Behavioural external memory holding the tree and chain tables.
// Assumes the engine keeps at most one read outstanding.
`timescale 1ns/1ps
`default_nettype none
module psc_mem_model (
	// Clock
	input  wire logic        ref_clk,
	// Read port
	input  wire logic        mem_rd,
	input  wire logic [23:0] mem_addr,
	output var  logic        mem_rvalid,
	output var  logic [31:0] mem_rdata
);
	logic [31:0] m [int];
	int          lat = 1;
	int          cnt = 0;
	int          a   = 0;
	initial begin
		mem_rvalid = 1'b0;
		mem_rdata  = 32'h0;
	end
	// Idle data toggles so a stale value is never mistaken for a reply
	always @(posedge ref_clk) begin
		mem_rvalid <= 1'b0;
		mem_rdata  <= ~mem_rdata;
		if (mem_rd) begin
			a   = int'(mem_addr);
			cnt = lat;
		end else if (cnt > 0) begin
			cnt = cnt - 1;
			if (cnt == 0) begin
				mem_rvalid <= 1'b1;
				mem_rdata  <= m.exists(a) ? m[a] : 32'h0;
			end
		end
	end
endmodule : psc_mem_model
`default_nettype wire

// >>> verification/psc_assertions.sv
// Port checker of the engine.
// Assumes clk_en held high by the bench.
`timescale 1ns/1ps
`default_nettype none
module psc_assertions (
	// Clock and reset
	input wire logic              ref_clk,
	input wire logic              arst_n,
	input wire logic              clk_en,
	// Ports
	input wire logic              req_valid,
	input wire psc_pkg::psc_req_t req,
	input wire logic              req_ready,
	input wire logic              mem_rd,
	input wire logic [23:0]       mem_addr,
	input wire logic              mem_rvalid,
	input wire logic [31:0]       mem_rdata,
	input wire logic              res_valid,
	input wire psc_pkg::psc_res_t res,
	input wire logic              fatal_err,
	input wire logic              fatal_clr
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	logic pend;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			pend <= 1'b0;
		else if (mem_rd)
			pend <= 1'b1;
		else if (mem_rvalid)
			pend <= 1'b0;
	end
	AST_ROOT_FIRST: assert property (req_valid && req_ready && clk_en |-> ##2
		mem_rd && mem_addr == $past(req.root, 2)) else $error("first read not at root");
	AST_ONE_READ: assert property (mem_rd |-> !pend) else $error("second read outstanding");
	AST_BUSY: assert property (req_valid && req_ready && clk_en |=> !req_ready [*4])
		else $error("ready during search");
	AST_IDLE_QUIET: assert property (req_ready |-> !mem_rd && !pend) else $error("read when idle");
	AST_RES_PULSE: assert property (res_valid |=> !res_valid) else $error("result not a pulse");
	AST_RES_HOLD: assert property (!res_valid |-> $stable(res)) else $error("result moved");
	AST_DFLT_CPU: assert property (res_valid && res.dflt |->
		res.dest == psc_pkg::PSC_DEST_CPU) else $error("default dest wrong");
	AST_FATAL_HOLD: assert property (fatal_err && !fatal_clr |=> fatal_err)
		else $error("fatal flag lost");
	AST_FATAL_BUSY: assert property ($rose(fatal_err) |-> !req_ready) else $error("fatal when idle");
	AST_READY_BACK: assert property (res_valid |-> ##[0:1] req_ready) else $error("ready late");
endmodule : psc_assertions
bind psc_engine psc_assertions u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
	.req_valid(req_valid), .req(req), .req_ready(req_ready), .mem_rd(mem_rd),
	.mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
	.res_valid(res_valid), .res(res), .fatal_err(fatal_err), .fatal_clr(fatal_clr));
`default_nettype wire

// >>> verification/tb.sv
// Bench: tree hit, flow table, chain, miss and duplicate searches.
// Assumes the memory model answers in lat cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic              ref_clk   = 0;
	logic              arst_n    = 0;
	logic              req_valid = 0;
	logic              fatal_clr = 0;
	psc_pkg::psc_req_t req       = '0;
	psc_pkg::psc_res_t res;
	logic              req_ready, mem_rd, mem_rvalid, res_valid, fatal_err;
	logic [23:0]       mem_addr;
	logic [31:0]       mem_rdata;
	int                fails = 0, checks = 0, cyc = 0;
	localparam logic [59:0] KR = 60'h800000000000003, KL = 60'h400000000000003;
	localparam logic [59:0] KH = 60'hc00000000000003;
	psc_engine u_psc_engine (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(1'b1),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
		.res_valid(res_valid), .res(res), .fatal_err(fatal_err), .fatal_clr(fatal_clr));
	psc_mem_model u_psc_mem_model (.ref_clk(ref_clk), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			results();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task results();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : results
	task wr(input int a, input logic [31:0] d);
		u_psc_mem_model.m[a] = d;
	endtask : wr
	task node(input int a, input logic [59:0] k, input int l, r, c);
		wr(a, {4'h0, k[59:32]});
		wr(a + 4, k[31:0]);
		wr(a + 8, l);
		wr(a + 12, r);
		wr(a + 16, c);
	endtask : node
	task cs(input int a, input logic [31:0] ctrl, nxt, hdr);
		wr(a, ctrl);
		wr(a + 4, nxt);
		wr(a + 8, hdr);
	endtask : cs
	function automatic logic [1:0] dact(input logic [3:0] p);
		return 2'(p % 4'd3 + 4'd1);
	endfunction : dact
	// Fill flow table: only bit x set, or only bit x clear
	task ft(input logic [7:0] x, input logic on);
		for (int w = 0; w < 8; w++)
			wr(32'h400 + 4 * w, {32{~on}} ^ ((w == x[7:5]) ? 32'h8000_0000 >> x[4:0] : 32'h0));
	endtask : ft
	task srch(input logic [59:0] k, input logic [31:0] h);
		int n;
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req.key <= k;
		req.hdr[0] <= h;
		n = 0;
		do @(negedge ref_clk); while (req_ready !== 1'b1 && ++n < 500);
		chk(32'(n < 500), 32'h1);
		@(posedge ref_clk);
		req_valid <= 1'b0;
		n = 0;
		do @(negedge ref_clk); while (res_valid !== 1'b1 && ++n < 500);
		chk(32'(n < 500), 32'h1);
	endtask : srch
	task s_flow();
		logic [7:0] ix [3];
		ix = '{8'd0, 8'd37, 8'd255};
		for (int i = 0; i < 3; i++) begin
			cs(32'h600, {4'hb, 20'h0, ix[i]}, 0, 32'hcafe_0001);
			ft(ix[i], 1'b1);
			srch(KL, 32'hcafe_0001);
			chk(res, {2'b00, 2'b11, 4'h0, 1'b0});
			ft(ix[i], 1'b0);
			srch(KL, 32'hcafe_0001);
			chk(res, {dact(4'h3), 2'b01, 4'hc, 1'b1});
		end
	endtask : s_flow
	task s_dup();
		wr(32'h784, 32'h7c0);
		cs(32'h7c0, 32'h2000_0000, 0, 32'hcafe_0002);
		srch(KH, 32'hcafe_0002);
		chk(fatal_err, 1'b1);
		@(posedge ref_clk) fatal_clr <= 1'b1;
		@(posedge ref_clk) fatal_clr <= 1'b0;
		@(negedge ref_clk);
		chk(fatal_err, 1'b0);
	endtask : s_dup
	initial begin
		req.root = 24'h000100;
		req.ft_ptr = 24'h000400;
		req.hdr_len = 4'h1;
		node(32'h100, KR, 32'h200, 32'h300, 32'h500);
		node(32'h200, KL, 0, 0, 32'h600);
		node(32'h300, KH, 0, 0, 32'h700);
		cs(32'h500, 32'h2000_0000, 0, 32'hcafe_0000);
		cs(32'h700, 32'h3000_0000, 32'h780, 32'h0bad_0bad);
		cs(32'h780, 32'h0, 0, 32'hcafe_0002);
		for (int p = 0; p < 16; p++)
			wr(32'h1800 + 32'h80 * p, {dact(p[3:0]), 2'b00, ~p[3:0], 24'h0});
		repeat (6) @(posedge ref_clk);
		chk(req_ready, 1'b0);
		arst_n <= 1'b1;
		srch(KR, 32'hcafe_0000);
		chk(res, {2'b00, 2'b10, 4'h0, 1'b0});
		cs(32'h500, 32'h4500_0000, 0, 32'hcafe_0000);
		wr(32'h50c, 32'h1234_5678);
		@(posedge ref_clk);
		req.hdr_len <= 4'h2;
		req.hdr[1]  <= 32'h1234_5678;
		srch(KR, 32'hcafe_0000);
		chk(res, {2'b11, 2'b00, 4'h5, 1'b0});
		srch(KR, 32'hcafe_ffff);
		chk(res, {dact(4'h3), 2'b01, 4'hc, 1'b1});
		@(posedge ref_clk);
		req.hdr_len <= 4'h1;
		s_flow();
		u_psc_mem_model.lat = 5;
		srch(KH, 32'hcafe_0002);
		chk(res, 32'h0);
		u_psc_mem_model.lat = 1;
		for (int p = 0; p < 16; p++) begin
			srch({56'h20000000000000, p[3:0]}, 32'h0);
			chk(res, {dact(p[3:0]), 2'b01, ~p[3:0], 1'b1});
		end
		s_dup();
		results();
	end
endmodule : tb
`default_nettype wire
